//--- rtl/qfm_pkg.sv
// Package of constants and types for the QAM transmission frame mux
package qfm_pkg;
  // ---------------------------------------------------------------
  // Frame geometry
  // ---------------------------------------------------------------
  localparam logic [8:0] FRAME_LEN = 9'h195;
  localparam logic [8:0] PAYLOAD_LEN = 9'h190;
  localparam logic [8:0] HDR_LEN = 9'h005;
  localparam logic [8:0] OPS_LEN = 9'h003;
  localparam logic [8:0] SLOW_PAR_LEN = 9'h010;
  localparam logic [8:0] SLOW_MIN = 9'h014;
  localparam logic [8:0] SLOW_MAX = 9'h0C8;
  localparam logic [8:0] FAST_MAX = 9'h0B4;
  localparam logic [8:0] SINGLE_SLOW = 9'h0C8;
  // ---------------------------------------------------------------
  // Header content
  // ---------------------------------------------------------------
  localparam logic [7:0] SYNC_HI = 8'hF6;
  localparam logic [7:0] SYNC_LO = 8'h28;
  localparam logic [3:0] HDR_CRC_POLY = 4'h3;
  localparam int CTL_TRIG_BIT = 7;
  localparam int CTL_FLAG_BIT = 6;
  localparam int CTL_NTR_BIT = 0;
  // Octet positions within the header
  localparam logic [8:0] OCT_SYNC_HI = 9'h000;
  localparam logic [8:0] OCT_SYNC_LO = 9'h001;
  localparam logic [8:0] OCT_CTL1 = 9'h002;
  localparam logic [8:0] OCT_CTL3 = 9'h004;
  localparam logic [2:0] BIT_FIRST = 3'h7;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    FLD_HDR = 3'h0,
    FLD_SLOW_A = 3'h1,
    FLD_FAST_A = 3'h2,
    FLD_SLOW_B = 3'h3,
    FLD_FAST_B = 3'h4
  } qfm_fld_e;
  typedef enum logic [1:0] {
    RX_HUNT = 2'h0,
    RX_CHECK = 2'h1,
    RX_LOCK = 2'h2
  } qfm_rx_e;
endpackage

//--- rtl/qfm_oct_if.sv
// Octet stream carrier between the framer and its serialiser
`timescale 1ns/100ps
interface qfm_oct_if;
  logic [7:0] octet;
  logic load;
  logic need;
  modport src (output octet, output load, input need);
  modport dst (input octet, input load, output need);
endinterface

//--- rtl/qfm_ser.sv
// Octet to line bit serialiser, MSB first
`timescale 1ns/100ps
module qfm_ser (
  input wire logic clk_in,
  input wire logic nrst_in,
  qfm_oct_if.dst oct,
  output logic bit_out
);
  typedef struct packed {
    logic [7:0] sh;
    logic [2:0] idx;
    logic run;
  } qfm_ser_s;
  qfm_ser_s cur_ff;
  qfm_ser_s nxt_cur;

  always_comb begin
    nxt_cur = cur_ff;
    if (oct.load) begin
      nxt_cur.sh = oct.octet;
      nxt_cur.idx = qfm_pkg::BIT_FIRST;
      nxt_cur.run = 1'b1;
    end else if (cur_ff.run) begin
      nxt_cur.sh = {cur_ff.sh[6:0], 1'b0};
      nxt_cur.idx = cur_ff.idx - 3'h1;
      if (cur_ff.idx == 3'h0) begin
        nxt_cur.run = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign oct.need = !cur_ff.run || cur_ff.idx == 3'h0;
  assign bit_out = cur_ff.sh[7];

  a_msb_first: assert property (@(posedge clk_in) disable iff (!nrst_in)
    oct.load |=> bit_out == $past(oct.octet[7]))
    else $error("First bit is not the octet MSB");
endmodule

//--- rtl/qfm_crc4.sv
// Header CRC over 24 control bits, remainder of D^4 shift by D^4+D+1
`timescale 1ns/100ps
module qfm_crc4 (
  input wire logic [23:0] ctl_in,
  output logic [3:0] crc_out
);
  always_comb begin
    logic [23:0] m;
    logic [3:0] r;
    logic fb;
    m = ctl_in;
    r = 4'h0;
    fb = 1'b0;
    // CRC positions 0, 7, 8, 15 count as zero
    m[15] = 1'b0;
    m[8] = 1'b0;
    m[7] = 1'b0;
    m[0] = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      fb = r[3] ^ m[i];
      r = {r[2:0], 1'b0};
      if (fb) begin
        r = r ^ qfm_pkg::HDR_CRC_POLY;
      end
    end
    crc_out = r;
  end
endmodule

//--- rtl/qfm_top.sv
// Transmission frame mux and demux for the medium convergence sublayer
`timescale 1ns/100ps
module qfm_top (
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  input wire logic CFG_DUAL_IN,
  input wire logic [7:0] CFG_QUICK_LEN_IN,
  input wire logic [4:0] CFG_QUICK_PAR_IN,
  input wire logic [23:0] TX_CTL_IN,
  input wire logic TX_TRIG_IN,
  input wire logic TX_FLAG_IN,
  input wire logic TX_TIMING_REF_IN,
  input wire logic [7:0] TX_DELAYED_DATA_IN,
  input wire logic [7:0] TX_QUICK_DATA_IN,
  input wire logic RX_BIT_IN,
  output logic TX_BIT_OUT,
  output logic TX_DELAYED_REQ_OUT,
  output logic TX_QUICK_REQ_OUT,
  output logic TX_FRAME_START_OUT,
  output logic CFG_ERR_OUT,
  output logic QUICK_UNCODED_OUT,
  output logic [7:0] RX_OCTET_OUT,
  output logic RX_DELAYED_VLD_OUT,
  output logic RX_QUICK_VLD_OUT,
  output logic RX_CW_FIRST_OUT,
  output logic [23:0] RX_CTL_OUT,
  output logic RX_CTL_VLD_OUT,
  output logic RX_CRC_ERR_OUT,
  output logic RX_LOCK_OUT
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [8:0] tx_pos;
    logic [8:0] rx_pos;
    qfm_pkg::qfm_rx_e rx_st;
    logic [2:0] rx_bits;
    logic [7:0] rx_sh;
    logic [7:0] rx_prev;
    logic [23:0] rx_ctl;
    logic [1:0] rx_sync;
    logic [7:0] s_len;
    logic [7:0] f_len;
    logic cfg_err;
    logic uncoded;
    logic [23:0] tx_ctl;
    logic tx_bit;
    logic d_req;
    logic q_req;
    logic fstart;
    logic [7:0] rx_oct;
    logic rx_dv;
    logic rx_qv;
    logic rx_first;
    logic [23:0] rx_ctl_o;
    logic rx_ctl_v;
    logic rx_crc_err;
    logic rx_lock;
  } qfm_top_s;
  qfm_top_s cur_ff;
  qfm_top_s nxt_cur;

  qfm_oct_if oct ();
  logic ser_bit;
  logic [3:0] tx_crc;
  logic [3:0] rx_crc;
  logic [23:0] tx_ctl_raw;
  logic [7:0] tx_octet;
  logic [7:0] rx_octet_w;
  logic [8:0] rx_pos_n;

  // Field of a frame octet position, shared by both directions
  function automatic qfm_pkg::qfm_fld_e fld_of(input logic [8:0] pos,
      input logic [7:0] s_len, input logic [7:0] f_len, output logic first);
    logic [8:0] p;
    logic [8:0] s;
    logic [8:0] f;
    p = pos - qfm_pkg::HDR_LEN;
    s = {1'b0, s_len};
    f = {1'b0, f_len};
    first = 1'b0;
    if (pos < qfm_pkg::HDR_LEN) begin
      fld_of = qfm_pkg::FLD_HDR;
    end else if (p < s) begin
      fld_of = qfm_pkg::FLD_SLOW_A;
      first = p == 9'h000;
    end else if (p < s + f) begin
      fld_of = qfm_pkg::FLD_FAST_A;
      first = p == s;
    end else if (p < s + f + s) begin
      fld_of = qfm_pkg::FLD_SLOW_B;
      first = p == s + f;
    end else begin
      fld_of = qfm_pkg::FLD_FAST_B;
      first = p == s + f + s;
    end
  endfunction

  // ---------------------------------------------------------------
  // Transmit header
  // ---------------------------------------------------------------
  always_comb begin
    tx_ctl_raw = cur_ff.tx_ctl;
    tx_ctl_raw[16 + qfm_pkg::CTL_TRIG_BIT] = TX_TRIG_IN;
    tx_ctl_raw[16 + qfm_pkg::CTL_FLAG_BIT] = TX_FLAG_IN;
    tx_ctl_raw[16 + qfm_pkg::CTL_NTR_BIT] = TX_TIMING_REF_IN;
  end

  qfm_crc4 u_tx_crc (
    .ctl_in(tx_ctl_raw),
    .crc_out(tx_crc)
  );

  always_comb begin
    logic [23:0] c;
    logic cw_first;
    qfm_pkg::qfm_fld_e fcur;
    c = tx_ctl_raw;
    cw_first = 1'b0;
    fcur = fld_of(cur_ff.tx_pos, cur_ff.s_len, cur_ff.f_len, cw_first);
    c[15] = tx_crc[3];
    c[8] = tx_crc[2];
    c[7] = tx_crc[1];
    c[0] = tx_crc[0];
    case (cur_ff.tx_pos)
      9'h000: tx_octet = qfm_pkg::SYNC_HI;
      9'h001: tx_octet = qfm_pkg::SYNC_LO;
      9'h002: tx_octet = c[23:16];
      9'h003: tx_octet = c[15:8];
      9'h004: tx_octet = c[7:0];
      default: tx_octet = '0;
    endcase
    // Lane octet requested one load earlier, chosen by field of position
    if (fcur inside {qfm_pkg::FLD_SLOW_A, qfm_pkg::FLD_SLOW_B}) begin
      tx_octet = TX_DELAYED_DATA_IN;
    end else if (fcur != qfm_pkg::FLD_HDR) begin
      tx_octet = TX_QUICK_DATA_IN;
    end
  end

  assign oct.octet = tx_octet;
  assign oct.load = oct.need;

  qfm_ser u_ser (
    .clk_in(CLK_IN),
    .nrst_in(NRST_IN),
    .oct(oct.dst),
    .bit_out(ser_bit)
  );

  // ---------------------------------------------------------------
  // Receive CRC
  // ---------------------------------------------------------------
  qfm_crc4 u_rx_crc (
    .ctl_in(cur_ff.rx_ctl),
    .crc_out(rx_crc)
  );

  assign rx_octet_w = {cur_ff.rx_sh[6:0], cur_ff.rx_sync[1]};

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic fst;
    logic sync_hit;
    qfm_pkg::qfm_fld_e f;
    nxt_cur = cur_ff;
    fst = 1'b0;
    sync_hit = 1'b0;
    f = qfm_pkg::FLD_HDR;
    rx_pos_n = '0;
    nxt_cur.tx_bit = ser_bit;
    nxt_cur.rx_sync = {cur_ff.rx_sync[0], RX_BIT_IN};
    nxt_cur.tx_ctl = TX_CTL_IN;
    nxt_cur.fstart = 1'b0;
    nxt_cur.rx_dv = 1'b0;
    nxt_cur.rx_qv = 1'b0;
    nxt_cur.rx_first = 1'b0;
    nxt_cur.rx_ctl_v = 1'b0;
    nxt_cur.rx_crc_err = 1'b0;

    // Lane lengths from transport class, fixed by configuration
    if (CFG_DUAL_IN) begin
      nxt_cur.f_len = CFG_QUICK_LEN_IN;
      nxt_cur.s_len = 8'(({1'b0, qfm_pkg::SINGLE_SLOW} -
          {1'b0, 1'b0, CFG_QUICK_LEN_IN}) & 10'h0FF);
    end else begin
      nxt_cur.f_len = 8'h00;
      nxt_cur.s_len = qfm_pkg::SINGLE_SLOW[7:0];
    end
    nxt_cur.cfg_err = CFG_QUICK_LEN_IN[0] ||
        ({1'b0, CFG_QUICK_LEN_IN} > qfm_pkg::FAST_MAX) ||
        ({1'b0, nxt_cur.s_len} < qfm_pkg::SLOW_MIN) ||
        !(CFG_QUICK_PAR_IN inside {5'h00, 5'h02, 5'h04, 5'h10}) ||
        ({1'b0, CFG_QUICK_LEN_IN} < {4'h0, CFG_QUICK_PAR_IN}) ||
        (CFG_DUAL_IN && CFG_QUICK_LEN_IN == 8'h00);
    nxt_cur.uncoded = CFG_DUAL_IN && CFG_QUICK_PAR_IN == 5'h00;

    // Transmit sequencing, one octet per serialiser load
    if (oct.need) begin
      nxt_cur.fstart = cur_ff.tx_pos == qfm_pkg::OCT_SYNC_HI;
      if (cur_ff.tx_pos == qfm_pkg::FRAME_LEN - 9'h001) begin
        nxt_cur.tx_pos = '0;
      end else begin
        nxt_cur.tx_pos = cur_ff.tx_pos + 9'h001;
      end
      f = fld_of(nxt_cur.tx_pos, cur_ff.s_len, cur_ff.f_len, fst);
      nxt_cur.d_req = f inside {qfm_pkg::FLD_SLOW_A,
          qfm_pkg::FLD_SLOW_B};
      nxt_cur.q_req = f inside {qfm_pkg::FLD_FAST_A,
          qfm_pkg::FLD_FAST_B};
    end else begin
      nxt_cur.d_req = 1'b0;
      nxt_cur.q_req = 1'b0;
    end

    // Receive bit shifter and octet alignment
    nxt_cur.rx_sh = rx_octet_w;
    nxt_cur.rx_bits = cur_ff.rx_bits + 3'h1;
    sync_hit = cur_ff.rx_prev == qfm_pkg::SYNC_HI &&
        rx_octet_w == qfm_pkg::SYNC_LO;
    case (cur_ff.rx_st)
      qfm_pkg::RX_HUNT: begin
        // Bitwise search over the last 16 line bits
        nxt_cur.rx_prev = {cur_ff.rx_prev[6:0], cur_ff.rx_sh[7]};
        if ({cur_ff.rx_prev[6:0], cur_ff.rx_sh[7], rx_octet_w} ==
            {qfm_pkg::SYNC_HI, qfm_pkg::SYNC_LO}) begin
          nxt_cur.rx_st = qfm_pkg::RX_CHECK;
          nxt_cur.rx_bits = 3'h0;
          nxt_cur.rx_pos = qfm_pkg::OCT_SYNC_LO;
        end
      end
      qfm_pkg::RX_CHECK, qfm_pkg::RX_LOCK: begin
        if (cur_ff.rx_bits == 3'h7) begin
          nxt_cur.rx_prev = rx_octet_w;
          rx_pos_n = (cur_ff.rx_pos == qfm_pkg::FRAME_LEN - 9'h001) ?
              9'h000 : cur_ff.rx_pos + 9'h001;
          nxt_cur.rx_pos = rx_pos_n;
          if (rx_pos_n == qfm_pkg::OCT_SYNC_LO) begin
            // Alignment seen again one frame later
            nxt_cur.rx_st = sync_hit ? qfm_pkg::RX_LOCK :
                qfm_pkg::RX_HUNT;
          end
          if (rx_pos_n >= qfm_pkg::OCT_CTL1 &&
              rx_pos_n <= qfm_pkg::OCT_CTL3) begin
            nxt_cur.rx_ctl = {cur_ff.rx_ctl[15:0], rx_octet_w};
            if (rx_pos_n == qfm_pkg::OCT_CTL3) begin
              nxt_cur.rx_ctl = {cur_ff.rx_ctl[15:0], rx_octet_w};
            end
          end
          if (cur_ff.rx_st == qfm_pkg::RX_LOCK) begin
            f = fld_of(rx_pos_n, cur_ff.s_len, cur_ff.f_len, fst);
            nxt_cur.rx_oct = rx_octet_w;
            nxt_cur.rx_first = fst;
            nxt_cur.rx_dv = f inside {qfm_pkg::FLD_SLOW_A,
                qfm_pkg::FLD_SLOW_B};
            nxt_cur.rx_qv = f inside {qfm_pkg::FLD_FAST_A,
                qfm_pkg::FLD_FAST_B};
          end
        end
        // Control field complete: check its CRC one cycle later
        if (cur_ff.rx_bits == 3'h0 && cur_ff.rx_pos == qfm_pkg::OCT_CTL3 &&
            cur_ff.rx_st == qfm_pkg::RX_LOCK) begin
          nxt_cur.rx_ctl_o = cur_ff.rx_ctl;
          nxt_cur.rx_ctl_v = 1'b1;
          nxt_cur.rx_crc_err = rx_crc != {cur_ff.rx_ctl[15],
              cur_ff.rx_ctl[8], cur_ff.rx_ctl[7], cur_ff.rx_ctl[0]};
        end
      end
      default: nxt_cur.rx_st = qfm_pkg::RX_HUNT;
    endcase
    nxt_cur.rx_lock = nxt_cur.rx_st == qfm_pkg::RX_LOCK;
  end

  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      cur_ff <= '0;
      cur_ff.rx_st <= qfm_pkg::RX_HUNT;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign TX_BIT_OUT = cur_ff.tx_bit;
  assign TX_DELAYED_REQ_OUT = cur_ff.d_req;
  assign TX_QUICK_REQ_OUT = cur_ff.q_req;
  assign TX_FRAME_START_OUT = cur_ff.fstart;
  assign CFG_ERR_OUT = cur_ff.cfg_err;
  assign QUICK_UNCODED_OUT = cur_ff.uncoded;
  assign RX_OCTET_OUT = cur_ff.rx_oct;
  assign RX_DELAYED_VLD_OUT = cur_ff.rx_dv;
  assign RX_QUICK_VLD_OUT = cur_ff.rx_qv;
  assign RX_CW_FIRST_OUT = cur_ff.rx_first;
  assign RX_CTL_OUT = cur_ff.rx_ctl_o;
  assign RX_CTL_VLD_OUT = cur_ff.rx_ctl_v;
  assign RX_CRC_ERR_OUT = cur_ff.rx_crc_err;
  assign RX_LOCK_OUT = cur_ff.rx_lock;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_frame_wrap: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    cur_ff.fstart |-> cur_ff.tx_pos == 9'h001)
    else $error("Frame start not at octet zero");
  a_sync_first: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    (oct.load && cur_ff.tx_pos == 9'h000) |-> tx_octet == 8'hF6)
    else $error("First header octet is not F6");
  a_sync_second: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    (oct.load && cur_ff.tx_pos == 9'h001) |-> tx_octet == 8'h28)
    else $error("Second header octet is not 28");
  a_lane_excl: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    !(cur_ff.d_req && cur_ff.q_req))
    else $error("Both lanes requested together");
  a_single_lat: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    !CFG_DUAL_IN |=> cur_ff.s_len == 8'hC8 && cur_ff.f_len == 8'h00)
    else $error("Single latency lengths wrong");
  a_odd_len: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    CFG_QUICK_LEN_IN[0] |=> CFG_ERR_OUT)
    else $error("Odd quick length not flagged");
  a_no_quick_single: assert property (@(posedge CLK_IN)
    disable iff (!NRST_IN)
    (!CFG_DUAL_IN ##1 !CFG_DUAL_IN) |-> !cur_ff.q_req)
    else $error("Quick lane requested in single latency");
  a_ntr_bit: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
    (oct.load && cur_ff.tx_pos == 9'h002) |->
    tx_octet[0] == TX_TIMING_REF_IN && tx_octet[7] == TX_TRIG_IN)
    else $error("Control octet one bits misplaced");
endmodule

//--- testbench/qfm_peer.sv
// Far-end framer model: records our line bits and sends its own frames
`timescale 1ns/100ps
module qfm_peer (
  input wire logic clk_in,
  input wire logic line_in,
  output logic line_out
);
  logic cap_q[$];
  logic send_q[$];
  initial line_out = 1'b0;
  always @(posedge clk_in) begin
    cap_q.push_back(line_in);
  end
  // Idle line toggles every cycle so no stale level is seen
  always @(negedge clk_in) begin
    if (send_q.size() > 0) begin
      line_out <= send_q.pop_front();
    end else begin
      line_out <= ~line_out;
    end
  end
  task automatic send_oct(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      send_q.push_back(b[i]);
    end
  endtask
endmodule

//--- testbench/tb.sv
// Self-checking bench for the transmission frame mux
`timescale 1ns/100ps
module tb;
  // -------------------------------------------------------------
  // Signals and case table
  // -------------------------------------------------------------
  typedef struct {
    logic dual;
    logic [7:0] flen;
    logic [4:0] par;
    logic [23:0] ctl;
    logic [2:0] tfm;
    logic err;
    logic unc;
  } qfm_row_s;
  logic clk, nrst, cfg_dual, tx_trig, tx_flag, tx_tref, rx_bit, tx_bit;
  logic d_req, q_req, f_start, cfg_err, q_unc, rx_dv, rx_qv, rx_first;
  logic rx_cv, rx_cerr, rx_lock, rx_err_seen;
  logic [7:0] cfg_flen, tx_dd, tx_qd, rx_oct;
  logic [4:0] cfg_par;
  logic [23:0] tx_ctl, rx_ctl, rx_ctl_seen;
  int mismatches, samples_checked, cyc, last_fs, fs_gap, d_k, q_k;
  int first_hits;
  qfm_row_s rows [8] = '{
    '{1'b0, 8'h00, 5'h00, 24'h123456, 3'h5, 1'b0, 1'b0},
    '{1'b1, 8'h64, 5'h10, 24'hFFFFFF, 3'h2, 1'b0, 1'b0},
    '{1'b1, 8'hB4, 5'h00, 24'h000000, 3'h7, 1'b0, 1'b1},
    '{1'b1, 8'h02, 5'h02, 24'hA5C3E1, 3'h0, 1'b0, 1'b0},
    '{1'b1, 8'h28, 5'h04, 24'h0F0F0F, 3'h1, 1'b0, 1'b0},
    '{1'b1, 8'h33, 5'h04, 24'h000000, 3'h0, 1'b1, 1'b0},
    '{1'b1, 8'hB6, 5'h10, 24'h000000, 3'h0, 1'b1, 1'b0},
    '{1'b1, 8'h10, 5'h05, 24'h000000, 3'h0, 1'b1, 1'b0}
  };
  qfm_top dut_u (
    .CLK_IN(clk), .NRST_IN(nrst), .CFG_DUAL_IN(cfg_dual),
    .CFG_QUICK_LEN_IN(cfg_flen), .CFG_QUICK_PAR_IN(cfg_par),
    .TX_CTL_IN(tx_ctl), .TX_TRIG_IN(tx_trig), .TX_FLAG_IN(tx_flag),
    .TX_TIMING_REF_IN(tx_tref), .TX_DELAYED_DATA_IN(tx_dd),
    .TX_QUICK_DATA_IN(tx_qd), .RX_BIT_IN(rx_bit), .TX_BIT_OUT(tx_bit),
    .TX_DELAYED_REQ_OUT(d_req), .TX_QUICK_REQ_OUT(q_req),
    .TX_FRAME_START_OUT(f_start), .CFG_ERR_OUT(cfg_err),
    .QUICK_UNCODED_OUT(q_unc), .RX_OCTET_OUT(rx_oct),
    .RX_DELAYED_VLD_OUT(rx_dv), .RX_QUICK_VLD_OUT(rx_qv),
    .RX_CW_FIRST_OUT(rx_first), .RX_CTL_OUT(rx_ctl),
    .RX_CTL_VLD_OUT(rx_cv), .RX_CRC_ERR_OUT(rx_cerr),
    .RX_LOCK_OUT(rx_lock)
  );
  qfm_peer peer_u (.clk_in(clk), .line_in(tx_bit), .line_out(rx_bit));
  // -------------------------------------------------------------
  // Models and checks
  // -------------------------------------------------------------
  function automatic logic [3:0] crc4(input logic [23:0] m);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 23; i >= 0; i--) begin
      r = {r[2:0], 1'b0} ^ ((r[3] ^ m[i]) ? 4'h3 : 4'h0);
    end
    return r;
  endfunction
  function automatic logic [23:0] exp_ctl(input qfm_row_s r);
    logic [23:0] e;
    e = r.ctl;
    {e[23], e[22], e[16]} = r.tfm;
    {e[15], e[8], e[7], e[0]} = 4'h0;
    {e[15], e[8], e[7], e[0]} = crc4(e);
    return e;
  endfunction
  // Field map: quick flag and octet index within the lane
  function automatic logic [8:0] pay(input int n, input int s, input int f);
    if (n < s) return {1'b0, 8'(n)};
    if (n < s + f) return {1'b1, 8'(n - s)};
    if (n < 2 * s + f) return {1'b0, 8'(n - f)};
    return {1'b1, 8'(n - 2 * s)};
  endfunction
  function automatic logic [7:0] oct(input int b);
    logic [7:0] v;
    for (int i = 0; i < 8; i++) v[7 - i] = peer_u.cap_q[b + i];
    return v;
  endfunction
  function automatic int find_sync();
    for (int i = 0; i + 16 <= peer_u.cap_q.size(); i++) begin
      if (oct(i) === qfm_pkg::SYNC_HI && oct(i + 8) === qfm_pkg::SYNC_LO)
        return i;
    end
    return -1;
  endfunction
  task automatic chk_bit(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_val(input string nm, input logic [23:0] e,
      input logic [23:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic close_out();
    $display("Checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // -------------------------------------------------------------
  // Stimulus
  // -------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Lane data follows each request; monitors and hang limit
  always @(negedge clk) begin
    cyc++;
    if (nrst !== 1'b1) begin
      d_k = 0;
      q_k = 0;
    end
    if (d_req === 1'b1) begin
      tx_dd <= 8'(d_k);
      d_k++;
    end
    if (q_req === 1'b1) begin
      tx_qd <= 8'(q_k) + 8'h80;
      q_k++;
    end
    if (f_start === 1'b1) begin
      fs_gap = cyc - last_fs;
      last_fs = cyc;
    end
    if (rx_cv === 1'b1) begin
      rx_ctl_seen = rx_ctl;
      rx_err_seen = rx_cerr;
    end
    if (rx_lock === 1'b1 && rx_first === 1'b1) begin
      chk_val("rx_first", rx_dv === 1'b1 ? 24'hC3 : 24'hA5,
          24'(rx_oct));
      chk_bit("rx_lane", 1'b1, rx_dv ^ rx_qv);
      first_hits++;
    end
    if (cyc == 60000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic do_reset(input qfm_row_s r);
    @(negedge clk);
    nrst = 1'b0;
    {cfg_dual, cfg_flen, cfg_par, tx_ctl} = {r.dual, r.flen, r.par, r.ctl};
    {tx_trig, tx_flag, tx_tref} = r.tfm;
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    peer_u.cap_q.delete();
  endtask
  task automatic run_row(input int k, input qfm_row_s r);
    int p, s, f;
    logic [8:0] m;
    logic [7:0] e8;
    do_reset(r);
    repeat (3300) @(negedge clk);
    chk_bit("cfg_err", r.err, cfg_err);
    if (r.err === 1'b0) begin
      chk_bit("uncoded", r.unc, q_unc);
      chk_val("frame_gap", 24'hCA8, 24'(fs_gap));
      f = r.dual ? int'(r.flen) : 0;
      s = 200 - f;
      p = find_sync();
      chk_bit("sync_found", 1'b1, p >= 0);
      chk_val("next_sync", 24'hF6, 24'(oct(p + 3240)));
      chk_val("ctl", exp_ctl(r),
          {oct(p + 16), oct(p + 24), oct(p + 32)});
      for (int n = 0; n < 400; n++) begin
        m = pay(n, s, f);
        e8 = m[8] ? m[7:0] + 8'h80 : m[7:0];
        chk_val("payload", {16'h0, e8},
            24'(oct(p + 40 + 8 * n)));
      end
    end
    $display("Row %0d done", k);
  endtask
  task automatic rx_test();
    qfm_row_s r;
    logic [23:0] c;
    logic [8:0] m;
    logic first;
    r = '{1'b1, 8'h28, 5'h10, 24'h5A5A5A, 3'h5, 1'b0, 1'b0};
    do_reset(r);
    c = exp_ctl(r);
    for (int k = 0; k < 4; k++) begin
      peer_u.send_oct(qfm_pkg::SYNC_HI);
      peer_u.send_oct(qfm_pkg::SYNC_LO);
      peer_u.send_oct(c[23:16]);
      peer_u.send_oct(c[15:8]);
      peer_u.send_oct(k == 3 ? c[7:0] ^ 8'h01 : c[7:0]);
      for (int n = 0; n < 400; n++) begin
        m = pay(n, 160, 40);
        first = m[7:0] == 8'h00 || m[7:0] == (m[8] ? 8'h28 : 8'hA0);
        peer_u.send_oct(m[8] ? (first ? 8'hA5 : 8'h5A) :
            (first ? 8'hC3 : 8'h11));
      end
    end
    repeat (9730) @(negedge clk);
    chk_bit("rx_lock", 1'b1, rx_lock);
    chk_val("rx_ctl", c, rx_ctl_seen);
    chk_bit("rx_crc_ok", 1'b0, rx_err_seen);
    repeat (200) @(negedge clk);
    chk_bit("rx_crc_bad", 1'b1, rx_err_seen);
    repeat (3200) @(negedge clk);
    chk_bit("rx_lost", 1'b0, rx_lock);
    chk_bit("rx_first_seen", 1'b1, first_hits > 0);
    $display("Receive test done");
  endtask
  task automatic reset_test();
    int p;
    do_reset(rows[1]);
    repeat (1000) @(negedge clk);
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    chk_val("rst_outs", 24'h0, {17'h0, tx_bit, d_req, q_req, f_start,
        cfg_err, q_unc, rx_lock});
    nrst = 1'b1;
    peer_u.cap_q.delete();
    repeat (40) @(negedge clk);
    p = find_sync();
    chk_bit("restart", 1'b1, p >= 0 && p < 8);
    $display("Reset test done");
  endtask
  initial begin
    {nrst, cfg_dual, cfg_flen, cfg_par, tx_ctl, tx_dd, tx_qd} = '0;
    {tx_trig, tx_flag, tx_tref} = 3'h0;
    {mismatches, samples_checked, cyc, last_fs, fs_gap, first_hits} = '0;
    rx_ctl_seen = 24'h0;
    rx_err_seen = 1'b0;
    for (int k = 0; k < 8; k++) begin
      run_row(k, rows[k]);
    end
    reset_test();
    rx_test();
    close_out();
  end
endmodule
